// ===== design/pfs_defs.svh
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH
// Bus word offsets (byte addresses)
`define PFS_OFF_PCL        8'h08
`define PFS_OFF_FLAGS      8'h0C
`define PFS_OFF_PCFULL     8'h10
`define PFS_OFF_STACK      8'h14
`define PFS_OFF_MAINCFG    8'h18
`define PFS_OFF_EXTCFG     8'h1C
`define PFS_OFF_IDENT      8'h20
`define PFS_OFF_PROG       8'h24
`define PFS_OFF_OPTION     8'h28
`define PFS_OFF_CLKINFO    8'h2C
// Flag register fields
`define PFS_FLG_PAGE_LSB   5
`define PFS_FLG_TO         4
`define PFS_FLG_PD         3
`define PFS_FLG_Z          2
`define PFS_FLG_DC         1
`define PFS_FLG_C          0
// Main configuration fields
`define PFS_MCFG_TURBO     11
// Extended configuration fields
`define PFS_XCFG_TRIM2     11
`define PFS_XCFG_PINS      10
`define PFS_XCFG_TRIM1     9
`define PFS_XCFG_TRIM0     8
`define PFS_XCFG_OPTX      7
`define PFS_XCFG_CINN      6
`define PFS_XCFG_BOR_LSB   4
// Reset values and fixed constants
`define PFS_RST_PC         11'h7FF
`define PFS_RST_FLAGS      8'h18
`define PFS_RST_MCFG       12'hFFF
`define PFS_RST_XCFG       12'hFFF
`define PFS_RST_OPTION     8'hFF
`define PFS_BOR_OFF        2'h3
`define PFS_DEEP_STACK     4'h8
`define PFS_SHALLOW_STACK  4'h2
`define PFS_BAD_ADDR_DATA  32'h0000_0000
`endif

// ===== design/pfs_pkg.sv
package pfs_pkg;
    typedef enum logic [3:0]
    {
        PFS_OP_NONE   = 4'h0,
        PFS_OP_ADD    = 4'h1,
        PFS_OP_SUB    = 4'h2,
        PFS_OP_RR     = 4'h3,
        PFS_OP_RL     = 4'h4,
        PFS_OP_LOGIC  = 4'h5,
        PFS_OP_JUMP   = 4'h6,
        PFS_OP_CALL   = 4'h7,
        PFS_OP_RET    = 4'h8,
        PFS_OP_WDCLR  = 4'h9,
        PFS_OP_SLEEP  = 4'hA,
        PFS_OP_WRPCL  = 4'hB,
        PFS_OP_WRFLG  = 4'hC
    } pfs_op_t;

    typedef enum logic [1:0]
    {
        PFS_BUS_IDLE = 2'b00,
        PFS_BUS_ACK  = 2'b01
    } pfs_bus_t;

    typedef struct packed
    {
        pfs_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] imm;
        logic       wdt_timeout;
    } pfs_req_t;

    typedef struct packed
    {
        logic [10:0]       pc;
        logic [7:0]        flags;
        logic [7:0]        result;
        logic [7:0]        option;
        logic [11:0]       mcfg;
        logic [11:0]       xcfg;
        logic [7:0][10:0]  stack;
        logic [3:0]        depth;
        logic              prog_mode;
        logic              bor_en;
        logic              clk_div4;
        logic [2:0]        osc_trim;
        logic              pins28;
        logic [1:0]        bor_sel;
        pfs_bus_t          bus;
        logic [31:0]       rdata;
        logic              stack_ovf;
        logic [1:0]        sync_a;
        logic [1:0]        sync_b;
    } pfs_state_t;
endpackage

// ===== design/pfs_core.sv
`timescale 1ns/1ps
`include "pfs_defs.svh"
module pfs_core
    import pfs_pkg::*;
#(
    parameter logic [11:0] IDENT_WORD = 12'h5A5  // Arbitrary value
)
(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    // Instruction-side request from the core sequencer
    input  wire pfs_req_t    REQ,
    // Programming-mode strap pin
    input  wire logic        PROG_PIN,
    // Avalon-MM slave
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Core-facing state
    output logic      [10:0] FETCH_ADDR,
    output logic      [7:0]  FLAGS,
    output logic      [7:0]  ALU_RESULT,
    output logic             CLK_DIV4,
    output logic      [2:0]  OSC_TRIM,
    output logic             PINS_28,
    output logic      [1:0]  BOR_SELECT,
    output logic             BOR_ENABLE,
    output logic             STACK_OVERFLOW
);
    pfs_state_t s_r;
    pfs_state_t s_nxt;

    function automatic logic [3:0] stack_limit(input logic [11:0] x);
        stack_limit = x[`PFS_XCFG_OPTX] ? `PFS_SHALLOW_STACK : `PFS_DEEP_STACK;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        merge = r;
    endfunction

    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic        cin;
    logic [7:0]  fl;
    logic [31:0] wv;
    logic        bus_req;
    logic        prog_sync;

    always_comb
    begin
        s_nxt     = s_r;
        fl        = s_r.flags;
        sum9      = 9'h000;
        sum5      = 5'h00;
        wv        = 32'h0000_0000;
        prog_sync = s_r.sync_a[1];
        bus_req   = AVS_READ || AVS_WRITE;
        s_nxt.sync_a = {s_r.sync_a[0], PROG_PIN};
        s_nxt.sync_b = s_r.sync_b;
        s_nxt.prog_mode = prog_sync;
        // Carry input only when active-low enable cleared
        cin = !s_r.xcfg[`PFS_XCFG_CINN] && s_r.flags[`PFS_FLG_C];
        s_nxt.pc = s_r.pc + 11'h001;
        unique case (REQ.op)
            PFS_OP_ADD:
            begin
                sum9 = {1'b0, REQ.a} + {1'b0, REQ.b} + {8'h00, cin};
                sum5 = {1'b0, REQ.a[3:0]} + {1'b0, REQ.b[3:0]} + {4'h0, cin};
                fl[`PFS_FLG_C]  = sum9[8];
                fl[`PFS_FLG_DC] = sum5[4];
                fl[`PFS_FLG_Z]  = (sum9[7:0] == 8'h00);
                s_nxt.result = sum9[7:0];
            end
            PFS_OP_SUB:
            begin
                // a - b as a + ~b + 1, carry in replaces the implicit one
                sum9 = {1'b0, REQ.a} + {1'b0, ~REQ.b}
                     + {8'h00, s_r.xcfg[`PFS_XCFG_CINN] ? 1'b1 : cin};
                sum5 = {1'b0, REQ.a[3:0]} + {1'b0, ~REQ.b[3:0]}
                     + {4'h0, s_r.xcfg[`PFS_XCFG_CINN] ? 1'b1 : cin};
                fl[`PFS_FLG_C]  = sum9[8];
                fl[`PFS_FLG_DC] = sum5[4];
                fl[`PFS_FLG_Z]  = (sum9[7:0] == 8'h00);
                s_nxt.result = sum9[7:0];
            end
            PFS_OP_RR:
            begin
                s_nxt.result = {s_r.flags[`PFS_FLG_C], REQ.a[7:1]};
                fl[`PFS_FLG_C] = REQ.a[0];
            end
            PFS_OP_RL:
            begin
                s_nxt.result = {REQ.a[6:0], s_r.flags[`PFS_FLG_C]};
                fl[`PFS_FLG_C] = REQ.a[7];
            end
            PFS_OP_LOGIC:
            begin
                s_nxt.result = REQ.a;
                fl[`PFS_FLG_Z] = (REQ.a == 8'h00);
            end
            PFS_OP_JUMP:
            begin
                s_nxt.pc = {s_r.flags[7:`PFS_FLG_PAGE_LSB], REQ.imm};
            end
            PFS_OP_CALL:
            begin
                // Push return address; oldest entry lost on overflow
                s_nxt.stack = {s_r.stack[6:0], s_r.pc + 11'h001};
                if (s_r.depth == stack_limit(s_r.xcfg))
                begin
                    s_nxt.stack_ovf = 1'b1;
                end
                else
                begin
                    s_nxt.depth = s_r.depth + 4'h1;
                end
                s_nxt.pc = {s_r.flags[7:`PFS_FLG_PAGE_LSB], REQ.imm};
            end
            PFS_OP_RET:
            begin
                s_nxt.pc    = s_r.stack[0];
                s_nxt.stack = {s_r.stack[7], s_r.stack[7:1]};
                if (s_r.depth != 4'h0)
                begin
                    s_nxt.depth = s_r.depth - 4'h1;
                end
            end
            PFS_OP_WDCLR:
            begin
                fl[`PFS_FLG_TO] = 1'b1;
                fl[`PFS_FLG_PD] = 1'b1;
            end
            PFS_OP_SLEEP:
            begin
                fl[`PFS_FLG_TO] = 1'b1;
                fl[`PFS_FLG_PD] = 1'b0;
            end
            PFS_OP_WRPCL:
            begin
                s_nxt.pc = {s_r.flags[7:`PFS_FLG_PAGE_LSB], REQ.imm};
            end
            PFS_OP_WRFLG:
            begin
                // Write first, then the Z flag from the written value lands on top
                fl = {REQ.imm[7:5], s_r.flags[4:3], REQ.imm[2:0]};
                fl[`PFS_FLG_Z] = (REQ.imm == 8'h00);
                s_nxt.result = REQ.imm;
            end
            default:
            begin
            end
        endcase
        if (REQ.wdt_timeout)
        begin
            fl[`PFS_FLG_TO] = 1'b0;
        end
        s_nxt.flags = fl;

        // Derived configuration
        s_nxt.clk_div4 = s_r.mcfg[`PFS_MCFG_TURBO];
        s_nxt.osc_trim = {s_r.xcfg[`PFS_XCFG_TRIM2], s_r.xcfg[`PFS_XCFG_TRIM1],
                          s_r.xcfg[`PFS_XCFG_TRIM0]};
        s_nxt.pins28   = s_r.xcfg[`PFS_XCFG_PINS];
        s_nxt.bor_sel  = s_r.xcfg[`PFS_XCFG_BOR_LSB +: 2];
        s_nxt.bor_en   = (s_r.xcfg[`PFS_XCFG_BOR_LSB +: 2] != `PFS_BOR_OFF);
        if (s_r.xcfg[`PFS_XCFG_OPTX])
        begin
            s_nxt.option[7:6] = 2'b11;
        end

        // Bus slave: one wait cycle, then answer
        unique case (s_r.bus)
            PFS_BUS_IDLE:
            begin
                if (bus_req)
                begin
                    s_nxt.bus = PFS_BUS_ACK;
                    s_nxt.rdata = `PFS_BAD_ADDR_DATA;
                    unique case (AVS_ADDRESS)
                        `PFS_OFF_PCL:     s_nxt.rdata = {24'h0, s_r.pc[7:0]};
                        `PFS_OFF_FLAGS:   s_nxt.rdata = {24'h0, s_r.flags};
                        `PFS_OFF_PCFULL:  s_nxt.rdata = {21'h0, s_r.pc};
                        `PFS_OFF_STACK:   s_nxt.rdata = {27'h0, s_r.stack_ovf, s_r.depth};
                        `PFS_OFF_MAINCFG: s_nxt.rdata = s_r.prog_mode ? {20'h0, s_r.mcfg}
                                                                      : 32'h0;
                        `PFS_OFF_EXTCFG:  s_nxt.rdata = s_r.prog_mode ? {20'h0, s_r.xcfg}
                                                                      : 32'h0;
                        `PFS_OFF_IDENT:   s_nxt.rdata = {20'h0, IDENT_WORD};
                        `PFS_OFF_PROG:    s_nxt.rdata = {31'h0, s_r.prog_mode};
                        `PFS_OFF_OPTION:  s_nxt.rdata = {24'h0, s_r.option};
                        `PFS_OFF_CLKINFO: s_nxt.rdata = {26'h0, s_r.bor_en, s_r.pins28,
                                                         s_r.osc_trim, s_r.clk_div4};
                        default:          s_nxt.rdata = `PFS_BAD_ADDR_DATA;
                    endcase
                end
            end
            PFS_BUS_ACK:
            begin
                s_nxt.bus = PFS_BUS_IDLE;
                if (AVS_WRITE)
                begin
                    unique case (AVS_ADDRESS)
                        `PFS_OFF_PCL:
                        begin
                            wv = merge({24'h0, s_r.pc[7:0]}, AVS_WRITEDATA, AVS_BYTEENABLE);
                            s_nxt.pc = {s_r.flags[7:`PFS_FLG_PAGE_LSB], wv[7:0]};
                        end
                        `PFS_OFF_FLAGS:
                        begin
                            wv = merge({24'h0, fl}, AVS_WRITEDATA, AVS_BYTEENABLE);
                            s_nxt.flags = {wv[7:5], fl[4:3], wv[2:0]};
                        end
                        `PFS_OFF_MAINCFG:
                        begin
                            if (s_r.prog_mode)
                            begin
                                wv = merge({20'h0, s_r.mcfg}, AVS_WRITEDATA, AVS_BYTEENABLE);
                                s_nxt.mcfg = wv[11:0];
                            end
                        end
                        `PFS_OFF_EXTCFG:
                        begin
                            if (s_r.prog_mode)
                            begin
                                wv = merge({20'h0, s_r.xcfg}, AVS_WRITEDATA, AVS_BYTEENABLE);
                                s_nxt.xcfg = wv[11:0];
                            end
                        end
                        `PFS_OFF_OPTION:
                        begin
                            wv = merge({24'h0, s_r.option}, AVS_WRITEDATA, AVS_BYTEENABLE);
                            s_nxt.option = s_r.xcfg[`PFS_XCFG_OPTX] ? {2'b11, wv[5:0]}
                                                                    : wv[7:0];
                        end
                        `PFS_OFF_STACK:
                        begin
                            // An overflow in the same cycle wins over the clear
                            if (AVS_WRITEDATA[4] && AVS_BYTEENABLE[0]
                                && !(REQ.op == PFS_OP_CALL
                                     && s_r.depth == stack_limit(s_r.xcfg)))
                            begin
                                s_nxt.stack_ovf = 1'b0;
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            default:
            begin
                s_nxt.bus = PFS_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            s_r           <= '0;
            s_r.pc        <= `PFS_RST_PC;
            s_r.flags     <= `PFS_RST_FLAGS;
            s_r.option    <= `PFS_RST_OPTION;
            s_r.mcfg      <= `PFS_RST_MCFG;
            s_r.xcfg      <= `PFS_RST_XCFG;
            s_r.bor_sel   <= `PFS_BOR_OFF;
            s_r.clk_div4  <= 1'b1;
            s_r.pins28    <= 1'b1;
            s_r.osc_trim  <= 3'h7;
            s_r.bus       <= PFS_BUS_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign AVS_READDATA    = s_r.rdata;
    assign AVS_WAITREQUEST = (s_r.bus == PFS_BUS_IDLE);
    assign FETCH_ADDR      = s_r.pc;
    assign FLAGS           = s_r.flags;
    assign ALU_RESULT      = s_r.result;
    assign CLK_DIV4        = s_r.clk_div4;
    assign OSC_TRIM        = s_r.osc_trim;
    assign PINS_28         = s_r.pins28;
    assign BOR_SELECT      = s_r.bor_sel;
    assign BOR_ENABLE      = s_r.bor_en;
    assign STACK_OVERFLOW  = s_r.stack_ovf;
endmodule

// ===== bench/pfs_core_monitor.sv
`timescale 1ns/1ps
`include "pfs_defs.svh"
module pfs_core_monitor
    import pfs_pkg::*;
(
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        SYS_RST,
    // Stimulus
    input wire pfs_req_t    REQ,
    input wire logic [7:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    // Answers
    input wire logic        AVS_WAITREQUEST,
    input wire logic [10:0] FETCH_ADDR,
    input wire logic [7:0]  FLAGS,
    input wire logic [7:0]  ALU_RESULT,
    input wire logic [1:0]  BOR_SELECT,
    input wire logic        BOR_ENABLE,
    input wire logic        STACK_OVERFLOW
);
    logic        wr_ack;
    logic        quiet;
    logic        rot_c;
    logic [10:0] tgt;
    logic [4:0]  flg_exp;
    // A bus write at the ack edge overrides the instruction, so it is left out
    assign wr_ack  = AVS_WRITE && !AVS_WAITREQUEST;
    assign quiet   = !wr_ack && !REQ.wdt_timeout;
    assign rot_c   = (REQ.op == PFS_OP_RR) ? REQ.a[0] : REQ.a[7];
    assign tgt     = {FLAGS[7:5], REQ.imm};
    assign flg_exp = {AVS_WRITEDATA[7:5], FLAGS[4:3]};
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);
    property p_rst_top;
        $fell(SYS_RST) |-> FETCH_ADDR == 11'h7FF;
    endproperty
    a_rst_top: assert property (p_rst_top) else $error("pc not at top");
    property p_incr;
        // Reset is still sampled high at the release edge, the counter holds there
        !SYS_RST && REQ.op == PFS_OP_NONE && quiet
            |=> FETCH_ADDR == $past(FETCH_ADDR) + 11'h001;
    endproperty
    a_incr: assert property (p_incr) else $error("pc did not step");
    property p_branch;
        (REQ.op == PFS_OP_JUMP || REQ.op == PFS_OP_CALL) && quiet |=> FETCH_ADDR == $past(tgt);
    endproperty
    a_branch: assert property (p_branch) else $error("branch target wrong");
    property p_flgwr;
        wr_ack && AVS_ADDRESS == `PFS_OFF_FLAGS && REQ.op == PFS_OP_NONE && !REQ.wdt_timeout
            |=> FLAGS[7:3] == $past(flg_exp);
    endproperty
    a_flgwr: assert property (p_flgwr) else $error("flag write wrong");
    property p_sleep;
        REQ.op == PFS_OP_SLEEP && quiet |=> FLAGS[4:3] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_clr;
        REQ.op == PFS_OP_WDCLR && quiet |=> FLAGS[4:3] == 2'b11;
    endproperty
    a_clr: assert property (p_clr) else $error("clear flags wrong");
    property p_tmo;
        REQ.wdt_timeout |=> FLAGS[4] == 1'b0;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout flag kept");
    property p_zero;
        REQ.op == PFS_OP_ADD && quiet |=> FLAGS[2] == (ALU_RESULT == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_rot;
        (REQ.op == PFS_OP_RR || REQ.op == PFS_OP_RL) && quiet |=> FLAGS[0] == $past(rot_c);
    endproperty
    a_rot: assert property (p_rot) else $error("rotate carry wrong");
    property p_bor;
        BOR_ENABLE == (BOR_SELECT != `PFS_BOR_OFF);
    endproperty
    a_bor: assert property (p_bor) else $error("brown-out enable wrong");
    property p_bus;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer wrong");
    c_sleep: cover property (REQ.op == PFS_OP_SLEEP);
    c_ovf: cover property ($rose(STACK_OVERFLOW));
    c_pcl: cover property (wr_ack && AVS_ADDRESS == `PFS_OFF_PCL);
endmodule
bind pfs_core pfs_core_monitor i_mon
(
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REQ(REQ), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .FETCH_ADDR(FETCH_ADDR), .FLAGS(FLAGS),
    .ALU_RESULT(ALU_RESULT), .BOR_SELECT(BOR_SELECT), .BOR_ENABLE(BOR_ENABLE),
    .STACK_OVERFLOW(STACK_OVERFLOW)
);

// ===== bench/program_flow_status_config_tb_top.sv
`timescale 1ns/1ps
`include "pfs_defs.svh"
module program_flow_status_config_tb_top
    import pfs_pkg::*;
;
    logic        ref_clk;
    logic        sys_rst;
    pfs_req_t    req;
    logic        prog_pin;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [10:0] fetch_addr;
    logic [7:0]  flags;
    logic [7:0]  alu_result;
    logic        clk_div4;
    logic [2:0]  osc_trim;
    logic        pins_28;
    logic [1:0]  bor_select;
    logic        bor_enable;
    logic        stack_overflow;
    logic [31:0] rd;
    int          n_errors;
    int          cmp_count;
    pfs_core #(.IDENT_WORD(12'h3C6)) i_dut // Arbitrary value
    (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .REQ(req), .PROG_PIN(prog_pin),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .FETCH_ADDR(fetch_addr), .FLAGS(flags),
        .ALU_RESULT(alu_result), .CLK_DIV4(clk_div4), .OSC_TRIM(osc_trim),
        .PINS_28(pins_28), .BOR_SELECT(bor_select), .BOR_ENABLE(bor_enable),
        .STACK_OVERFLOW(stack_overflow)
    );
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Waits for the answer with no assumed latency; the answer or the bound of 50 cycles ends it
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge ref_clk);
        avs_address   <= addr;
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= wdata;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        chk("bus answer", 1'b1, n < 50);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic op(input pfs_op_t o, input logic [7:0] a, b, imm, input logic t);
        @(posedge ref_clk);
        req <= '{o, a, b, imm, t};
        @(posedge ref_clk);
        req <= '{PFS_OP_NONE, a, b, imm, 1'b0};
        #1;
    endtask
    task automatic alu(input pfs_op_t o, input logic [7:0] a, b, r, rm, input logic [2:0] f, fm);
        op(o, a, b, 8'h00, 1'b0);
        chk("alu result", r & rm, alu_result & rm);
        chk("alu flags", f & fm, flags[2:0] & fm);
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial
    begin
        #100000;
        n_errors++;
        close_out();
    end
    initial
    begin
        sys_rst       = 1'b1;
        req           = '0;
        prog_pin      = 1'b0;
        avs_address   = 8'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        n_errors      = 0;
        cmp_count     = 0;
        repeat (5) @(posedge ref_clk);
        #1;
        chk("pc in reset", 11'h7FF, fetch_addr);
        chk("flags in reset", 8'h18, flags);
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("pc wrap", 11'h000, fetch_addr);
        bus(1'b1, `PFS_OFF_PCL, 32'h0000_00F0);
        #1;
        chk("pc low write", 8'hF0, fetch_addr[7:0]);
        // Attempt to clear both read-only bits while setting page 1
        bus(1'b1, `PFS_OFF_FLAGS, 32'h0000_0027);
        bus(1'b0, `PFS_OFF_FLAGS, 32'h0);
        chk("flag readback", 8'h38, rd[7:0] & 8'hF8);
        op(PFS_OP_JUMP, 8'h00, 8'h00, 8'hFF, 1'b0);
        chk("jump target", 11'h1FF, fetch_addr);
        @(posedge ref_clk);
        #1;
        chk("page crossing", 11'h200, fetch_addr);
        bus(1'b1, `PFS_OFF_FLAGS, 32'h0000_0060);
        op(PFS_OP_CALL, 8'h00, 8'h00, 8'h10, 1'b0);
        chk("call target", 11'h310, fetch_addr);
        op(PFS_OP_CALL, 8'h00, 8'h00, 8'h20, 1'b0);
        op(PFS_OP_CALL, 8'h00, 8'h00, 8'h30, 1'b0);
        chk("shallow overflow", 1'b1, stack_overflow);
        bus(1'b0, `PFS_OFF_STACK, 32'h0);
        chk("shallow depth", 5'h12, rd[4:0]);
        bus(1'b1, `PFS_OFF_STACK, 32'h0000_0010);
        op(PFS_OP_RET, 8'h00, 8'h00, 8'h00, 1'b0);
        chk("return address", 11'h322, fetch_addr);
        op(PFS_OP_RET, 8'h00, 8'h00, 8'h00, 1'b0);
        chk("second return", 11'h312, fetch_addr);
        bus(1'b0, `PFS_OFF_STACK, 32'h0);
        chk("stack empty", 5'h00, rd[4:0]);
        bus(1'b1, `PFS_OFF_OPTION, 32'h0);
        bus(1'b0, `PFS_OFF_OPTION, 32'h0);
        chk("forced option bits", 8'hC0, rd[7:0]);
        alu(PFS_OP_RR, 8'h01, 8'h00, 8'h00, 8'hFF, 3'b001, 3'b001);
        alu(PFS_OP_ADD, 8'h0F, 8'h01, 8'h10, 8'hFF, 3'b010, 3'b111);
        alu(PFS_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'hFF, 3'b111, 3'b111);
        alu(PFS_OP_SUB, 8'h10, 8'h01, 8'h0F, 8'hFF, 3'b001, 3'b111);
        alu(PFS_OP_SUB, 8'h01, 8'h02, 8'hFF, 8'hFF, 3'b000, 3'b111);
        alu(PFS_OP_SUB, 8'h05, 8'h05, 8'h00, 8'hFF, 3'b111, 3'b111);
        alu(PFS_OP_RL, 8'h7F, 8'h00, 8'hFF, 8'hFF, 3'b000, 3'b001);
        op(PFS_OP_WRFLG, 8'h00, 8'h00, 8'h00, 1'b0);
        chk("flag write by op", 8'h1C, flags & 8'hFC);
        op(PFS_OP_SLEEP, 8'h00, 8'h00, 8'h00, 1'b0);
        chk("after sleep", 2'b10, flags[4:3]);
        op(PFS_OP_NONE, 8'h00, 8'h00, 8'h00, 1'b1);
        chk("after timeout", 2'b00, flags[4:3]);
        op(PFS_OP_WDCLR, 8'h00, 8'h00, 8'h00, 1'b0);
        chk("after clear", 2'b11, flags[4:3]);
        op(PFS_OP_WDCLR, 8'h00, 8'h00, 8'h00, 1'b1);
        chk("timeout wins", 2'b01, flags[4:3]);
        bus(1'b1, `PFS_OFF_MAINCFG, 32'h0);
        bus(1'b0, `PFS_OFF_MAINCFG, 32'h0);
        chk("config hidden", 32'h0, rd);
        chk("divide kept", 1'b1, clk_div4);
        prog_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        bus(1'b1, `PFS_OFF_MAINCFG, 32'h0000_07FF);
        bus(1'b1, `PFS_OFF_EXTCFG, 32'h0000_0210);
        bus(1'b1, `PFS_OFF_IDENT, 32'h0);
        bus(1'b0, `PFS_OFF_IDENT, 32'h0);
        chk("ident word", 12'h3C6, rd);
        bus(1'b0, `PFS_OFF_MAINCFG, 32'h0);
        chk("main config", 12'h7FF, rd);
        chk("clock divide", 1'b0, clk_div4);
        chk("osc trim", 3'b010, osc_trim);
        chk("pin count", 1'b0, pins_28);
        chk("bor select", 2'b01, bor_select);
        chk("bor enable", 1'b1, bor_enable);
        bus(1'b1, `PFS_OFF_OPTION, 32'h0);
        bus(1'b0, `PFS_OFF_OPTION, 32'h0);
        chk("free option bits", 8'h00, rd[7:0]);
        avs_byteenable <= 4'h0;
        bus(1'b1, `PFS_OFF_OPTION, 32'h0000_00FF);
        avs_byteenable <= 4'hF;
        bus(1'b0, `PFS_OFF_OPTION, 32'h0);
        chk("masked option write", 8'h00, rd[7:0]);
        alu(PFS_OP_RL, 8'h80, 8'h00, 8'h00, 8'hFF, 3'b001, 3'b001);
        alu(PFS_OP_ADD, 8'h01, 8'h01, 8'h03, 8'hFF, 3'b000, 3'b001);
        alu(PFS_OP_SUB, 8'h05, 8'h03, 8'h01, 8'hFF, 3'b000, 3'b000);
        for (int i = 0; i < 9; i++)
            op(PFS_OP_CALL, 8'h00, 8'h00, 8'(i), 1'b0);
        bus(1'b0, `PFS_OFF_STACK, 32'h0);
        chk("deep depth", 5'h18, rd[4:0]);
        bus(1'b0, `PFS_OFF_PROG, 32'h0);
        chk("program mode", 32'h1, rd);
        bus(1'b0, `PFS_OFF_CLKINFO, 32'h0);
        chk("clock info", 32'h0000_0024, rd);
        prog_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        bus(1'b0, `PFS_OFF_EXTCFG, 32'h0);
        chk("config hidden again", 32'h0, rd);
        bus(1'b0, 8'h3C, 32'h0);
        chk("unmapped read", 32'h0, rd);
        op(PFS_OP_WRPCL, 8'h00, 8'h00, 8'h55, 1'b0);
        chk("pc write by op", 11'h055, fetch_addr);
        bus(1'b0, `PFS_OFF_PCFULL, 32'h0);
        chk("pc full read", 32'h0000_0056, rd);
        alu(PFS_OP_LOGIC, 8'h00, 8'h00, 8'h00, 8'hFF, 3'b100, 3'b100);
        close_out();
    end
endmodule
